// ---- src/rss_reset_sequencer.sv ----
// Reset sequencer, supply warning flag and system integrity register
`timescale 1ns/100ps
// Functional notes
// - Reset requests come from reset pin, low-supply detector and watchdog.
// - Illegal opcode or prebyte report also starts a reset.
// - All sources pull reset pin low; stays low through the delay.
// - After reset the core fetches vector at top of memory.
// - Sequence: source-dependent active phase, fixed delay, vector fetch.
// - Delay 256 cycles for RC or external clock, 4096 for crystal.
// - Vector fetch phase lasts two clock cycles.
// - With PLL enabled, clock output waits an extra PLL startup delay.
// - External reset pulse is caught asynchronously, even with clock halted.
// - Reset pin is bidirectional open drain with weak pull-up.
// - Low-supply reset held under rising or falling hysteresis threshold.
// - Detector enable and threshold level come from configuration bits.
// - Active low-supply reset holds the reset pin low.
// - Watchdog underflow drives pin low at least minimum pulse width.
// - Supply warning comparator output is a read-only real-time flag.
// - Warning detector inactive unless low-supply detector enabled.
// - Warning flag set raises irq if enabled and global mask clear.
// - In wait the monitor runs; warning irq wakes from wait.
// - In halt the stored register bits are frozen, live flags still follow; warning irq does not wake.
// - Register resets to 0110 0xx0.
// - Top bit follows fast PLL lock, hardware only.
// - Dog flag set by watchdog reset, cleared by write zero or low-supply.
// - Low-supply flag set on its reset, cleared on read.
// - Warning flag is one while supply under warning threshold.
// - Irq enable is read/write; pending irq clears on service entry.
module rss_reset_sequencer #(
  parameter int DelayLong = rss_pkg::DELAY_LONG,
  parameter int PllStartCyc = rss_pkg::PLL_START_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  input wire logic lowSupplyBelowRise,
  input wire logic lowSupplyBelowFall,
  input wire logic warnCompOut,
  input wire logic dogUnderflow,
  input wire logic illegalOpcode,
  input wire logic fastPllLocked,
  input wire logic pllLocked,
  input wire logic lowSupplyEnable,
  input wire rss_pkg::rss_level_t lowSupplyLevel,
  input wire rss_pkg::rss_clk_src_t clockSource,
  input wire logic pllEnable,
  input wire logic waitMode,
  input wire logic haltMode,
  input wire logic globalIrqMask,
  input wire logic irqServiceEntry,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  output logic coreReset_n,
  output logic vectorFetch,
  output logic [15:0] vectorAddr,
  output logic clockRelease,
  output logic warnIrq,
  output logic wakeRequest
);
  import rss_pkg::*;

  typedef enum logic [2:0] {ST_ACTIVE, ST_DELAY, ST_FETCH, ST_PLL, ST_RUN} rss_state_t;

  localparam logic [15:0] RESET_VECTOR = 16'hfffe;
  localparam logic [CNT_W-1:0] ONE = 24'h000001;

  rss_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic lowHold_q;
  logic lowReset;
  logic anyReset_n;
  logic relSync1_q;
  logic relSync2_q;
  logic lowSync1_q;
  logic lowSync2_q;
  logic warnSync1_q;
  logic warnSync2_q;
  logic dogActive_q;
  logic illegalActive_q;
  logic [CNT_W-1:0] pulseCnt_q;
  logic dogRf_q;
  logic lowRf_q;
  logic trim1_q;
  logic trim0_q;
  logic irqEn_q;
  logic warnPrev_q;
  logic irqPend_q;
  logic ownPinHold;
  logic pinRequest_n;
  logic [7:0] optsReg_q;
  logic warnFlag;
  logic [CNT_W-1:0] delayCyc;
  logic readSics;

  // Low-supply hysteresis from the two comparators
  always_comb begin
    lowReset = lowSupplyEnable & (lowHold_q ? lowSupplyBelowRise : lowSupplyBelowFall);
  end

  // Hysteresis memory: once below falling level, hold until above rising level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lowHold_q <= 1'b1;
    end else begin
      lowHold_q <= lowSync2_q;
    end
  end

  // Own pin drive from the delay on must not come back as a fresh reset request
  // Mask stays up after the delay so the pin's release cannot glitch the reset
  assign ownPinHold = (state_q == ST_DELAY) || (state_q == ST_FETCH) || (state_q == ST_PLL);
  assign pinRequest_n = resetPinIn | ownPinHold;

  // Asynchronous reset merge of pin, low supply, watchdog and illegal opcode
  assign anyReset_n = rst_n & pinRequest_n & ~lowReset & ~dogUnderflow & ~illegalOpcode;

  // Release synchroniser
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      relSync1_q <= 1'b0;
      relSync2_q <= 1'b0;
    end else begin
      relSync1_q <= 1'b1;
      relSync2_q <= relSync1_q;
    end
  end

  // Low-supply synchroniser for flags and hysteresis
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lowSync1_q <= 1'b0;
      lowSync2_q <= 1'b0;
    end else begin
      lowSync1_q <= lowReset;
      lowSync2_q <= lowSync1_q;
    end
  end

  // Warning comparator synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      warnSync1_q <= 1'b0;
      warnSync2_q <= 1'b0;
    end else begin
      warnSync1_q <= warnCompOut;
      warnSync2_q <= warnSync1_q;
    end
  end

  // Delay length from clock source
  assign delayCyc = (clockSource == CLK_XTAL) ? CNT_W'(DelayLong) : CNT_W'(DELAY_SHORT);

  // Sequencer: active, delay, fetch, optional PLL wait, run
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      state_q <= ST_ACTIVE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_ACTIVE: begin
          cnt_q <= '0;
          if (relSync2_q && pulseCnt_q == '0) begin
            state_q <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          cnt_q <= cnt_q + ONE;
          if (cnt_q == delayCyc - ONE) begin
            cnt_q <= '0;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          cnt_q <= cnt_q + ONE;
          if (cnt_q == CNT_W'(FETCH_CYCLES - 1)) begin
            cnt_q <= '0;
            state_q <= pllEnable ? ST_PLL : ST_RUN;
          end
        end
        ST_PLL: begin
          cnt_q <= cnt_q + ONE;
          if (cnt_q == CNT_W'(PllStartCyc - 1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Registered watchdog and illegal-opcode requests
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dogActive_q <= 1'b0;
      illegalActive_q <= 1'b0;
    end else begin
      dogActive_q <= dogUnderflow;
      illegalActive_q <= illegalOpcode;
    end
  end

  // Minimum output pulse after watchdog underflow, runs on plain reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulseCnt_q <= '0;
    end else if (dogUnderflow) begin
      pulseCnt_q <= CNT_W'(PULSE_MIN_CYC);
    end else if (pulseCnt_q != '0) begin
      pulseCnt_q <= pulseCnt_q - ONE;
    end
  end

  // Open-drain pin: low for internal requests and through the delay phase
  always_comb begin
    resetPinOut = 1'b0;
    resetPinOe = 1'b0;
    if (state_q == ST_DELAY) begin
      resetPinOe = 1'b1;
    end
    if (lowReset || dogUnderflow || illegalOpcode || illegalActive_q) begin
      resetPinOe = 1'b1;
    end
    // Watchdog stretch keeps the active phase going
    if (pulseCnt_q != '0) begin
      resetPinOe = 1'b1;
    end
  end

  // Core held in reset until the fetch phase
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      coreReset_n <= 1'b0;
    end else begin
      coreReset_n <= (state_q == ST_FETCH) || (state_q == ST_PLL) || (state_q == ST_RUN);
    end
  end

  // Two-cycle fetch strobe around the delay-to-fetch step
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      vectorFetch <= 1'b0;
    end else begin
      // Registered, so it rises on the edge that leaves the delay
      vectorFetch <= (state_q == ST_DELAY && cnt_q == delayCyc - ONE) ||
                     (state_q == ST_FETCH && cnt_q == '0);
    end
  end

  // Fixed reset vector at top of memory
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      vectorAddr <= 16'h0000;
    end else begin
      vectorAddr <= RESET_VECTOR;
    end
  end

  // Clock to the core, held back by the PLL wait
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      clockRelease <= 1'b0;
    end else begin
      clockRelease <= (state_q == ST_RUN) || (state_q == ST_FETCH && !pllEnable);
    end
  end

  // Warning flag: real-time comparator, only with detector enabled
  assign warnFlag = lowSupplyEnable & warnSync2_q;
  assign readSics = regRead && regAddr == ADDR_SICS;

  // Watchdog cause flag; frozen in halt, low-supply clear wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dogRf_q <= 1'b0;
    end else if (!haltMode) begin
      if (lowSync2_q) begin
        dogRf_q <= 1'b0;
      end else if (dogActive_q) begin
        dogRf_q <= 1'b1;
      end else if (regWrite && regAddr == ADDR_SICS && !regWrData[BIT_DOGRF]) begin
        dogRf_q <= 1'b0;
      end
    end
  end

  // Low-supply cause flag; set wins over the read clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lowRf_q <= 1'b0;
    end else if (!haltMode) begin
      if (lowSync2_q) begin
        lowRf_q <= 1'b1;
      end else if (readSics) begin
        lowRf_q <= 1'b0;
      end
    end
  end

  // Trim bits, back to ones on any reset
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      trim1_q <= TRIM_RESET;
      trim0_q <= TRIM_RESET;
    end else if (!haltMode && regWrite && regAddr == ADDR_SICS) begin
      trim1_q <= regWrData[BIT_TRIM1];
      trim0_q <= regWrData[BIT_TRIM0];
    end
  end

  // Supply warning interrupt enable
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      irqEn_q <= 1'b0;
    end else if (!haltMode && regWrite && regAddr == ADDR_SICS) begin
      irqEn_q <= regWrData[BIT_WARNIE];
    end
  end

  // Option shadow register, readable for software
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      optsReg_q <= 8'h00;
    end else begin
      optsReg_q <= {1'b0, pllEnable, clockSource, lowSupplyLevel, 1'b0, lowSupplyEnable};
    end
  end

  // Flag history for edge detection
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      warnPrev_q <= 1'b0;
    end else begin
      warnPrev_q <= warnFlag;
    end
  end

  // Warning interrupt pending: set on rising flag, set wins over service entry
  always_ff @(posedge clock or negedge anyReset_n) begin
    if (!anyReset_n) begin
      irqPend_q <= 1'b0;
    end else if (warnFlag && !warnPrev_q) begin
      irqPend_q <= 1'b1;
    end else if (irqServiceEntry) begin
      irqPend_q <= 1'b0;
    end
  end

  // Interrupt and wake requests
  always_comb begin
    warnIrq = irqPend_q & irqEn_q & ~globalIrqMask;
    wakeRequest = warnIrq & waitMode & ~haltMode;
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_SICS: regRdData <= {fastPllLocked, trim1_q, trim0_q, dogRf_q,
                                 pllLocked, lowRf_q, warnFlag, irqEn_q};
        ADDR_OPTS: regRdData <= optsReg_q;
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule

// ---- common/rss_pkg.sv ----
// Package for the reset sequencer and supply monitor
package rss_pkg;
  // Register map (plain port, byte index)
  localparam logic [1:0] ADDR_SICS = 2'h0;
  localparam logic [1:0] ADDR_OPTS = 2'h1;
  // Field positions of the integrity register
  localparam int BIT_FAST_PLL_LOCK_FLAG = 7;
  localparam int BIT_TRIM1 = 6;
  localparam int BIT_TRIM0 = 5;
  localparam int BIT_DOGRF = 4;
  localparam int BIT_LOCKED = 3;
  localparam int BIT_LOWRF = 2;
  localparam int BIT_WARNF = 1;
  localparam int BIT_WARNIE = 0;
  // Reset values of the writable trim bits
  localparam logic TRIM_RESET = 1'b1;
  // Clock source encodings from configuration
  typedef enum logic [1:0] {CLK_RC, CLK_EXT, CLK_XTAL, CLK_RSVD} rss_clk_src_t;
  // Threshold level encodings
  typedef enum logic [1:0] {LVL_LOW, LVL_MED, LVL_HIGH, LVL_RSVD} rss_level_t;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int DELAY_SHORT = 256;
  localparam int DELAY_LONG = 4096;
  localparam int FETCH_CYCLES = 2;
  localparam int PULSE_MIN_NS = 1000;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PLL_START_US = 1000;
  localparam int PLL_START_CYC = PLL_START_US * CLK_MHZ;
  localparam int CNT_W = 24;
endpackage

// ---- tb/rss_partner.sv ----
// Far side model: reset pin wire with outside circuitry and CPU core
`timescale 1ns/100ps
module rss_partner (
  input wire logic clock,
  input wire logic resetPinOe,
  input wire logic extPullLow,
  input wire logic warnIrq,
  output logic resetPinIn,
  output logic irqServiceEntry = 1'b0
);
  // Open-drain wire: either party pulls low, weak pull-up otherwise
  assign resetPinIn = !(resetPinOe || extPullLow);
  // Core enters the service routine one cycle after a request
  always @(posedge clock) begin
    irqServiceEntry <= warnIrq && !irqServiceEntry;
  end
endmodule

// ---- tb/rss_chk.sv ----
// Port checker for the reset sequencer, bound to its top module
`timescale 1ns/100ps
module rss_chk #(
  parameter int DelayLong = rss_pkg::DELAY_LONG
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic resetPinOe,
  input wire logic lowSupplyBelowFall,
  input wire logic warnCompOut,
  input wire logic dogUnderflow,
  input wire logic illegalOpcode,
  input wire logic lowSupplyEnable,
  input wire rss_pkg::rss_clk_src_t clockSource,
  input wire logic waitMode,
  input wire logic haltMode,
  input wire logic globalIrqMask,
  input wire logic [1:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic coreReset_n,
  input wire logic vectorFetch,
  input wire logic [15:0] vectorAddr,
  input wire logic warnIrq,
  input wire logic wakeRequest
);
  import rss_pkg::*;
  int oeCnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Length of the current pin-low stretch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) oeCnt <= 0;
    else oeCnt <= resetPinOe ? oeCnt + 1 : 0;
  end
  a_req_pin_low: assert property ((dogUnderflow || illegalOpcode) |-> resetPinOe) else $error("pin free");
  a_low_pin_held: assert property (lowSupplyEnable && lowSupplyBelowFall |-> resetPinOe) else $error("pin free");
  a_delay_hold: assert property ($rose(vectorFetch) |-> $past(resetPinOe)) else $error("pin free in delay");
  a_delay_len: assert property ($rose(vectorFetch) |->
    oeCnt >= ((clockSource == CLK_XTAL) ? DelayLong : DELAY_SHORT)) else $error("delay short");
  a_fetch_two: assert property ($rose(vectorFetch) |-> ##1 vectorFetch ##1 !vectorFetch) else $error("fetch len");
  a_vector_top: assert property (vectorFetch |-> vectorAddr == 16'hfffe) else $error("vector addr");
  a_warn_live: assert property (regRead && regAddr == ADDR_SICS && !haltMode && $stable(warnCompOut) &&
    $past(warnCompOut, 2) == warnCompOut |=>
    regRdData[BIT_WARNF] == (lowSupplyEnable && $past(warnCompOut))) else $error("warn flag");
  a_irq_gated: assert property (warnIrq |-> !globalIrqMask && lowSupplyEnable) else $error("irq ungated");
  a_halt_no_wake: assert property (haltMode |-> !wakeRequest) else $error("halt woken");
  a_wait_wakes: assert property (waitMode && !haltMode && warnIrq |-> wakeRequest) else $error("no wake");
  cover property ($rose(vectorFetch));
  cover property (warnIrq && waitMode);
  cover property (regRead && haltMode);
endmodule
bind rss_reset_sequencer rss_chk #(.DelayLong(DelayLong)) rss_chk_i (.clock, .rst_n, .resetPinOe,
  .lowSupplyBelowFall, .warnCompOut, .dogUnderflow, .illegalOpcode, .lowSupplyEnable, .clockSource,
  .waitMode, .haltMode, .globalIrqMask, .regAddr, .regRead, .regRdData, .coreReset_n, .vectorFetch,
  .vectorAddr, .warnIrq, .wakeRequest);

// ---- tb/tb_top.sv ----
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
module tb_top;
  import rss_pkg::*;
  localparam int DLong = 16;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic extPull, resetPinIn, resetPinOe, svcEntry, belowRise, belowFall, warnCompOut, dogUnderflow;
  logic illegalOpcode, fastPllLocked, pllLocked, lowSupplyEnable, pllEnable, waitMode, haltMode;
  logic globalIrqMask, regWrite, regRead, coreReset_n, vectorFetch, warnIrq, expDog, h;
  rss_pkg::rss_level_t lowSupplyLevel;
  rss_pkg::rss_clk_src_t clockSource;
  logic [1:0] regAddr, a;
  logic [7:0] regWrData, regRdData, d, w, held;
  logic [15:0] vectorAddr;
  int seed = 3;
  int mismatches = 0;
  int nChecks = 0;
  int oe, n, kind;
  // Free-running clock
  always #4 clock = ~clock;
  rss_reset_sequencer #(.DelayLong(DLong), .PllStartCyc(10)) rss_reset_sequencer_i (.clock, .rst_n,
    .resetPinIn, .resetPinOut(), .resetPinOe, .lowSupplyBelowRise(belowRise), .lowSupplyBelowFall(belowFall),
    .warnCompOut, .dogUnderflow, .illegalOpcode, .fastPllLocked, .pllLocked, .lowSupplyEnable,
    .lowSupplyLevel, .clockSource, .pllEnable, .waitMode, .haltMode, .globalIrqMask,
    .irqServiceEntry(svcEntry), .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .coreReset_n,
    .vectorFetch, .vectorAddr, .clockRelease(), .warnIrq, .wakeRequest());
  rss_partner rss_partner_i (.clock, .resetPinOe, .extPullLow(extPull), .warnIrq, .resetPinIn,
    .irqServiceEntry(svcEntry));
  // Comparison and bus helpers
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    nChecks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [1:0] ad, logic [7:0] dt);
    regAddr <= ad;
    regWrData <= dt;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(logic [1:0] ad, output logic [7:0] dt);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    dt = regRdData;
    @(posedge clock);
  endtask
  task automatic waitFetch(output int cnt);
    cnt = 0;
    for (int i = 0; i < 9000 && vectorFetch !== 1'b1; i++) begin
      @(negedge clock);
      if (resetPinOe === 1'b1) cnt++;
    end
    repeat (4) @(posedge clock);
  endtask
  function automatic logic [7:0] sics(logic [7:0] v, logic lo);
    return {fastPllLocked, v[6:5], expDog, pllLocked, lo, warnCompOut & lowSupplyEnable, v[0]};
  endfunction
  function automatic logic [7:0] expRd(logic [1:0] ad);
    case (ad)
      ADDR_SICS: return held;
      ADDR_OPTS: return {1'b0, pllEnable, clockSource, lowSupplyLevel, 1'b0, lowSupplyEnable};
      default: return 8'h00;
    endcase
  endfunction
  task automatic giveVerdict();
    if (mismatches == 0 && nChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial begin
    #400000;
    mismatches++;
    giveVerdict();
  end
  // Main sequence: power-up, every reset source per clock source, random register traffic
  initial begin
    {extPull, belowRise, belowFall, warnCompOut, dogUnderflow, illegalOpcode} = 6'h00;
    {fastPllLocked, pllLocked, pllEnable, waitMode, haltMode, globalIrqMask} = 6'h00;
    {regWrite, regRead, expDog, lowSupplyEnable} = 4'h1;
    lowSupplyLevel = LVL_LOW;
    clockSource = CLK_RC;
    regAddr = 2'h0;
    regWrData = 8'h00;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    waitFetch(oe);
    rd(ADDR_SICS, d);
    chk("por", 8'h60, d & 8'hf9);
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 4; k++) begin
        kind = (k + 3) % 4;
        clockSource <= rss_clk_src_t'(s);
        lowSupplyLevel <= rss_level_t'(s);
        extPull <= kind == 0;
        dogUnderflow <= kind == 1;
        illegalOpcode <= kind == 2;
        belowRise <= kind == 3;
        belowFall <= kind == 3;
        repeat (4) @(posedge clock);
        {extPull, dogUnderflow, illegalOpcode, belowRise, belowFall} <= 5'h00;
        waitFetch(oe);
        n = (s == 2) ? DLong : DELAY_SHORT;
        if (kind == 0) chk("delay", 8'h01, {7'h00, oe == n});
        chk("core", 8'h01, {7'h00, coreReset_n});
        expDog = (kind == 1) ? 1'b1 : (kind == 3) ? 1'b0 : expDog;
        rd(ADDR_SICS, d);
        chk("flags", sics(8'h60, kind == 3), d);
        rd(ADDR_SICS, d);
        chk("lowclr", sics(8'h60, 1'b0), d);
      end
    end
    held = sics(8'h60, 1'b0);
    repeat (60) begin
      h = $random(seed) % 4 == 0;
      haltMode <= h;
      @(posedge clock);
      {warnCompOut, globalIrqMask, waitMode, fastPllLocked, pllLocked} <= 5'($random(seed));
      a = 2'($random(seed));
      w = 8'($random(seed));
      repeat (3) @(posedge clock);
      if (!h) begin
        expDog = expDog & w[4];
      end
      held = sics(h ? held : w, 1'b0);
      wr(ADDR_SICS, w);
      rd(a, d);
      chk("reg", expRd(a), d);
    end
    giveVerdict();
  end
endmodule
